// File: hdl/bus_status_defines.vh
// Operation
// - Status lines code cycle type; 000 inta through 111 passive, active low.
// - DMA indicator high during second and later periods of DMA cycles.
// - DMA indicator released to high impedance during bus grant and reset.
// - Bus lock output low only during first period of a locked cycle.
// - Strap low during power-on reset disables PLL, clock divided by two.
// - Strap is sampled on the rising edge of reset.
// - Synchronous ready high means always ready; low hands control to async.
// - Asynchronous ready passes internal synchronisation before ending cycles.
// - Region four select asserts for memory accesses inside region four.
// - Auxiliary config bit 1 picks 8 or 16 bit width for region four.
// - Region four select is held high while bus is granted away.
// - Region four pin becomes general purpose when region one covers all.
// - Region four weak pull-up is enabled only during reset.
// - Refresh strobe only output while refresh control bit 15 is set.
// - Refresh strobe active 1.5 periods, then inactive for rest of cycle.
// - Refresh strobe keeps being driven during bus grant.
`ifndef BUS_STATUS_DEFINES_VH
`define BUS_STATUS_DEFINES_VH

`define CODE_INTA 3'h0
`define CODE_IO_READ 3'h1
`define CODE_IO_WRITE 3'h2
`define CODE_HALT 3'h3
`define CODE_FETCH 3'h4
`define CODE_MEM_READ 3'h5
`define CODE_MEM_WRITE 3'h6
`define CODE_PASSIVE 3'h7

`define AUX_WIDTH_BIT 1
`define REFRESH_EN_BIT 15
`define REFRESH_INTERVAL_MSB 8

`define STRAP_RESET_VALUE 1'b1
`define MID4_REGION_INDEX 2'h3

`define CLK_PERIOD_NS 100
`define REFRESH_CYCLE_NS 400
`define REFRESH_CYCLE_CLKS \
  ((`REFRESH_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: hdl/refresh_strobe.v
`timescale 1ns/1ps
`include "bus_status_defines.vh"

module refresh_strobe (
  input wire i_clk,
  input wire i_resetn,
  input wire i_enable,
  input wire [8:0] i_interval,
  output wire o_strobe_n,
  output reg o_refresh_req
);

  localparam [8:0] MIN_PERIOD = `REFRESH_CYCLE_CLKS;

  reg [8:0] count_q;
  reg [8:0] count_d;
  reg rise_q;
  reg fall_q;
  wire [8:0] period;

  // A period shorter than one refresh cycle would overlap strobes.
  assign period = (i_interval < MIN_PERIOD) ? MIN_PERIOD : i_interval;

  always @* begin
    count_d = count_q;
    if (!i_enable) begin
      count_d = 9'h000;
    end else if (count_q >= period - 9'h001) begin
      count_d = 9'h000;
    end else begin
      count_d = count_q + 9'h001;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= 9'h000;
      rise_q <= 1'b0;
      o_refresh_req <= 1'b0;
    end else begin
      count_q <= count_d;
      rise_q <= i_enable && (count_q == 9'h000);
      o_refresh_req <= i_enable && (count_q == 9'h000);
    end
  end

  // The falling-edge copy stretches the pulse by half a period, which is
  // the only way to reach 1.5 periods with a single clock.
  always @(negedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= rise_q;
    end
  end

  assign o_strobe_n = ~(rise_q | fall_q);

endmodule

// File: hdl/bus_cycle_status_and_ready.v
`timescale 1ns/1ps
`include "bus_status_defines.vh"

module bus_cycle_status_and_ready (
  input wire i_clk,
  input wire i_resetn,
  input wire i_cycle_start,
  input wire [2:0] i_cycle_type,
  input wire i_cycle_dma,
  input wire i_cycle_lock,
  input wire [19:0] i_cycle_addr,
  input wire i_bus_granted,
  input wire i_srdy,
  input wire i_ardy,
  input wire [19:0] i_mid_base,
  input wire [19:0] i_mid_region_size,
  input wire i_mid_whole_range,
  input wire [15:0] i_auxiliary_config_register,
  input wire [15:0] i_refresh_control_register,
  input wire i_divide_strap_in,
  output reg o_cycle_status_bit2,
  output reg o_cycle_status_bit1,
  output reg o_cycle_status_bit0,
  output reg o_dma_cycle_indicator,
  output reg o_dma_cycle_oe_n,
  output reg o_bus_lock_n,
  output reg o_cycle_busy,
  output reg o_cycle_done,
  output reg o_mid_region4_select_n,
  output reg o_mid4_bus_16bit,
  output reg o_gp_pin_mid4_alt,
  output reg o_mid4_pullup_en,
  output wire o_refresh_strobe_n,
  output reg o_refresh_req,
  output reg o_divided_clock_mode,
  output reg o_pll_enable
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_T1 = 3'h1;
  localparam [2:0] ST_T2 = 3'h2;
  localparam [2:0] ST_T3 = 3'h3;
  localparam [2:0] ST_T4 = 3'h4;

  // Memory cycles are the fetch, read and write codes.
  function is_mem_cycle;
    input [2:0] code;
    begin
      is_mem_cycle = (code == `CODE_FETCH) ||
                     (code == `CODE_MEM_READ) ||
                     (code == `CODE_MEM_WRITE);
    end
  endfunction

  // True when addr lies in region idx of the midrange block.
  function in_region;
    input [19:0] addr;
    input [19:0] base;
    input [19:0] size;
    input [1:0] idx;
    reg [21:0] lo;
    reg [21:0] hi;
    begin
      lo = {2'b00, base} + ({2'b00, size} * {20'h0_0000, idx});
      hi = lo + {2'b00, size};
      in_region = ({2'b00, addr} >= lo) && ({2'b00, addr} < hi);
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] type_q;
  reg dma_q;
  reg lock_q;
  reg [19:0] addr_q;

  reg srdy_meta_q;
  reg srdy_sync_q;
  reg ardy_meta_q;
  reg ardy_sync_q;
  reg strap_meta_q;
  reg strap_sync_q;
  reg strap_taken_q;

  reg [2:0] status_d;
  reg dma_ind_d;
  reg lock_n_d;
  reg mid4_n_d;
  wire ready;
  wire take;
  wire refresh_strobe_n;
  wire refresh_req;

  // Pin inputs, two stages each; nothing reads the first stage but the
  // second. Both readies are staged because the pins come from another
  // clock domain as far as this logic can know.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      srdy_meta_q <= 1'b0;
      srdy_sync_q <= 1'b0;
      ardy_meta_q <= 1'b0;
      ardy_sync_q <= 1'b0;
    end else begin
      srdy_meta_q <= i_srdy;
      srdy_sync_q <= srdy_meta_q;
      ardy_meta_q <= i_ardy;
      ardy_sync_q <= ardy_meta_q;
    end
  end

  // Synchronous ready high always completes; low defers to async ready.
  assign ready = srdy_sync_q | ardy_sync_q;

  // The strap stages carry no reset so they still follow the pin while
  // reset is held; the first edge after release sees the real level.
  always @(posedge i_clk) begin
    strap_meta_q <= i_divide_strap_in;
    strap_sync_q <= strap_meta_q;
  end

  // Every reset is treated as power-on here; there is no separate
  // warm reset input to tell them apart.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_taken_q <= 1'b0;
      o_divided_clock_mode <= 1'b0;
      o_pll_enable <= 1'b1;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      o_divided_clock_mode <= ~strap_sync_q;
      o_pll_enable <= strap_sync_q;
    end
  end

  assign take = i_cycle_start && !i_bus_granted;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_T1;
        end
      end
      ST_T1: begin
        state_d = ST_T2;
      end
      ST_T2: begin
        state_d = ST_T3;
      end
      ST_T3: begin
        // Wait states repeat here until ready is seen.
        if (ready) begin
          state_d = ST_T4;
        end
      end
      ST_T4: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      type_q <= `CODE_PASSIVE;
      dma_q <= 1'b0;
      lock_q <= 1'b0;
      addr_q <= 20'h0_0000;
    end else if (state_q == ST_IDLE && take) begin
      type_q <= i_cycle_type;
      dma_q <= i_cycle_dma;
      lock_q <= i_cycle_lock;
      addr_q <= i_cycle_addr;
    end
  end

  // Next values of the pin outputs, one cycle ahead of the state that
  // they describe, so each pin changes on the edge that enters it.
  always @* begin
    status_d = `CODE_PASSIVE;
    dma_ind_d = 1'b0;
    lock_n_d = 1'b1;
    mid4_n_d = 1'b1;
    case (state_d)
      ST_T1: begin
        status_d = (state_q == ST_IDLE) ? i_cycle_type : type_q;
        lock_n_d = ~((state_q == ST_IDLE) ? i_cycle_lock : lock_q);
        mid4_n_d = ~(is_mem_cycle(i_cycle_type) &&
                     in_region(i_cycle_addr, i_mid_base,
                               i_mid_region_size, `MID4_REGION_INDEX));
      end
      ST_T2, ST_T3: begin
        status_d = type_q;
        dma_ind_d = dma_q;
        mid4_n_d = ~(is_mem_cycle(type_q) &&
                     in_region(addr_q, i_mid_base,
                               i_mid_region_size, `MID4_REGION_INDEX));
      end
      ST_T4: begin
        dma_ind_d = dma_q;
        mid4_n_d = ~(is_mem_cycle(type_q) &&
                     in_region(addr_q, i_mid_base,
                               i_mid_region_size, `MID4_REGION_INDEX));
      end
      default: begin
        status_d = `CODE_PASSIVE;
      end
    endcase
    if (i_bus_granted) begin
      mid4_n_d = 1'b1;
    end
    if (i_mid_whole_range) begin
      mid4_n_d = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      o_cycle_status_bit2 <= 1'b1;
      o_cycle_status_bit1 <= 1'b1;
      o_cycle_status_bit0 <= 1'b1;
      o_dma_cycle_indicator <= 1'b0;
      o_dma_cycle_oe_n <= 1'b1;
      o_bus_lock_n <= 1'b1;
      o_cycle_busy <= 1'b0;
      o_cycle_done <= 1'b0;
      o_mid_region4_select_n <= 1'b1;
    end else begin
      state_q <= state_d;
      o_cycle_status_bit2 <= status_d[2];
      o_cycle_status_bit1 <= status_d[1];
      o_cycle_status_bit0 <= status_d[0];
      o_dma_cycle_indicator <= dma_ind_d;
      o_dma_cycle_oe_n <= i_bus_granted;
      o_bus_lock_n <= lock_n_d;
      o_cycle_busy <= (state_d != ST_IDLE);
      o_cycle_done <= (state_d == ST_T4);
      o_mid_region4_select_n <= mid4_n_d;
    end
  end

  // Width and pin mode follow software settings with one flop of delay.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mid4_bus_16bit <= 1'b0;
      o_gp_pin_mid4_alt <= 1'b0;
      o_mid4_pullup_en <= 1'b1;
    end else begin
      o_mid4_bus_16bit <=
        i_auxiliary_config_register[`AUX_WIDTH_BIT];
      o_gp_pin_mid4_alt <= i_mid_whole_range;
      o_mid4_pullup_en <= 1'b0;
    end
  end

  refresh_strobe u_refresh (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_enable(i_refresh_control_register[`REFRESH_EN_BIT]),
    .i_interval(i_refresh_control_register[`REFRESH_INTERVAL_MSB:0]),
    .o_strobe_n(refresh_strobe_n),
    .o_refresh_req(refresh_req)
  );

  // The strobe has no enable tied to the bus grant, so it keeps its
  // drive during hold.
  assign o_refresh_strobe_n = refresh_strobe_n;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_refresh_req <= 1'b0;
    end else begin
      o_refresh_req <= refresh_req;
    end
  end

endmodule

// File: tb/bus_cycle_status_and_ready_assertions.sv
`timescale 1ns/1ps
module bus_cycle_checker (
  input wire i_clk,
  input wire i_resetn,
  input wire [2:0] i_cycle_type,
  input wire i_cycle_dma,
  input wire i_cycle_lock,
  input wire i_bus_granted,
  input wire i_srdy,
  input wire i_ardy,
  input wire [15:0] i_refresh_control_register,
  input wire i_divide_strap_in,
  input wire o_cycle_status_bit2,
  input wire o_cycle_status_bit1,
  input wire o_cycle_status_bit0,
  input wire o_dma_cycle_indicator,
  input wire o_dma_cycle_oe_n,
  input wire o_bus_lock_n,
  input wire o_cycle_busy,
  input wire o_cycle_done,
  input wire o_mid_region4_select_n,
  input wire o_mid4_pullup_en,
  input wire o_refresh_strobe_n,
  input wire o_divided_clock_mode,
  input wire o_pll_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire [2:0] st = {o_cycle_status_bit2, o_cycle_status_bit1,
    o_cycle_status_bit0};
  wire any_rdy = i_srdy | i_ardy;
  wire rfe = i_refresh_control_register[15];
  sequence s_wait_t4;
    !o_cycle_done [*3];
  endsequence
  sequence s_dma_t2;
    !o_dma_cycle_indicator ##1 o_dma_cycle_indicator;
  endsequence
  chk_cycle_code:
  assert property ($rose(o_cycle_busy) |-> st == $past(i_cycle_type))
    else $error("bad cycle code");
  chk_passive_idle:
  assert property (!o_cycle_busy |-> st == 3'h7)
    else $error("idle code not passive");
  chk_dma_periods:
  assert property ($rose(o_cycle_busy) && $past(i_cycle_dma) |-> s_dma_t2)
    else $error("dma indicator wrong");
  chk_dma_release:
  assert property (i_bus_granted && $past(i_bus_granted) |-> o_dma_cycle_oe_n)
    else $error("dma pin driven in grant");
  chk_lock_first:
  assert property (!o_bus_lock_n |-> $rose(o_cycle_busy) && $past(i_cycle_lock))
    else $error("lock outside first period");
  chk_done_bound:
  assert property ($rose(o_cycle_busy) |-> s_wait_t4 ##[1:40] o_cycle_done)
    else $error("cycle end out of bounds");
  chk_ready_sync:
  assert property (o_cycle_done |-> $past(any_rdy, 3))
    else $error("ended without synced ready");
  chk_select_grant:
  assert property (i_bus_granted && $past(i_bus_granted) |->
    o_mid_region4_select_n)
    else $error("select low in grant");
  chk_pullup_run:
  assert property ($past(i_resetn) |-> !o_mid4_pullup_en)
    else $error("pullup on after reset");
  chk_refresh_off:
  assert property (!rfe && !$past(rfe) |-> o_refresh_strobe_n)
    else $error("strobe while disabled");
  chk_strobe_width:
  assert property ($fell(o_refresh_strobe_n) |=> o_refresh_strobe_n)
    else $error("strobe too long");
  chk_strap_sample:
  assert property ($past(i_resetn) && !$past(i_resetn, 2) |->
    o_divided_clock_mode == !$past(i_divide_strap_in) &&
    o_pll_enable == !o_divided_clock_mode)
    else $error("strap not applied");
endmodule

bind bus_cycle_status_and_ready bus_cycle_checker bus_cycle_checker_inst (.*);

// File: tb/ready_responder.sv
`timescale 1ns/1ps
module ready_responder (
  input wire i_clk,
  input wire i_busy,
  input wire i_done,
  input wire [4:0] i_waits,
  input wire [1:0] i_mode,
  output reg o_srdy = 1'b0,
  output reg o_ardy = 1'b0
);
  integer cnt = 0;
  // Ready stays a level until the cycle ends, so the synchronisers see it.
  // Mode 1 answers on the async line only, at a time off the clock grid.
  always @(negedge i_clk) begin
    if (!i_busy || i_done) begin
      cnt <= 0;
      o_srdy <= i_mode == 2'h2;
      o_ardy <= #37 1'b0;
    end else if (cnt >= i_waits) begin
      o_srdy <= i_mode != 2'h1;
      o_ardy <= #37 i_mode == 2'h1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg i_clk, i_resetn, i_cycle_start, i_cycle_dma, i_cycle_lock;
  reg [2:0] i_cycle_type;
  reg [19:0] i_cycle_addr, i_mid_base, i_mid_region_size;
  reg i_bus_granted, i_mid_whole_range, i_divide_strap_in;
  reg [15:0] i_auxiliary_config_register, i_refresh_control_register;
  reg [4:0] waits;
  reg [1:0] mode;
  wire i_srdy, i_ardy;
  wire o_cycle_status_bit2, o_cycle_status_bit1, o_cycle_status_bit0;
  wire o_dma_cycle_indicator, o_dma_cycle_oe_n, o_bus_lock_n, o_cycle_busy;
  wire o_cycle_done, o_mid_region4_select_n, o_mid4_bus_16bit;
  wire o_gp_pin_mid4_alt, o_mid4_pullup_en, o_refresh_strobe_n;
  wire o_refresh_req, o_divided_clock_mode, o_pll_enable;
  wire [2:0] st = {o_cycle_status_bit2, o_cycle_status_bit1,
    o_cycle_status_bit0};
  integer n_errors = 0, checks_done = 0, i, k, t0;
  bus_cycle_status_and_ready bus_cycle_status_and_ready_inst (.*);
  ready_responder ready_responder_inst (.i_clk(i_clk), .i_busy(o_cycle_busy),
    .i_done(o_cycle_done), .i_waits(waits), .i_mode(mode),
    .o_srdy(i_srdy), .o_ardy(i_ardy));
  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task bus_cycle(input [2:0] ty, input dma, input lock, input [19:0] a);
    integer n, lo, sel;
    begin
      lo = i_mid_base + 3 * i_mid_region_size;
      sel = ty >= 4 && ty <= 6 && !i_mid_whole_range && a >= lo &&
        a < lo + i_mid_region_size;
      i_cycle_type = ty;
      i_cycle_dma = dma;
      i_cycle_lock = lock;
      i_cycle_addr = a;
      i_cycle_start = 1;
      @(negedge i_clk);
      i_cycle_start = 0;
      check("status", st, ty);
      check("lock", o_bus_lock_n, !lock);
      check("select", o_mid_region4_select_n, !sel);
      @(negedge i_clk);
      check("dma", o_dma_cycle_indicator, dma);
      check("lock t2", o_bus_lock_n, 1);
      n = 0;
      while (o_cycle_done !== 1'b1 && n < 60) begin
        @(negedge i_clk);
        n = n + 1;
      end
      check("done", n < 60, 1);
      check("end code", st, 7);
      check("width", o_mid4_bus_16bit, i_auxiliary_config_register[1]);
      check("gp", o_gp_pin_mid4_alt, i_mid_whole_range);
      if (n == 60)
        final_report;
      @(negedge i_clk);
    end
  endtask
  task wait_lvl(input v);
    integer n;
    begin
      n = 0;
      while (o_refresh_strobe_n !== v && n < 2000) begin
        #10;
        n = n + 1;
      end
      check("strobe wait", n < 2000, 1);
      if (n == 2000)
        final_report;
    end
  endtask
  // One fall is skipped and timing starts at the second, so a period change has fully taken effect.
  task measure(input integer per);
    begin
      #1;
      wait_lvl(1);
      wait_lvl(0);
      wait_lvl(1);
      wait_lvl(0);
      t0 = $time;
      wait_lvl(1);
      check("low time", $time - t0, 150);
      check("req", o_refresh_req, 1);
      wait_lvl(0);
      check("period", $time - t0, 100 * per);
      @(negedge i_clk);
    end
  endtask
  initial begin
    i_resetn = 0;
    i_cycle_start = 0;
    i_cycle_type = 0;
    i_cycle_dma = 0;
    i_cycle_lock = 0;
    i_cycle_addr = 0;
    i_bus_granted = 0;
    i_mid_base = 20'h4_0000;
    i_mid_region_size = 20'h0_1000;
    i_mid_whole_range = 0;
    i_auxiliary_config_register = 0;
    i_refresh_control_register = 0;
    i_divide_strap_in = 0;
    waits = 0;
    mode = 0;
    k = $urandom(32'h8697_e21e);
    repeat (4) @(negedge i_clk);
    check("pullup rst", o_mid4_pullup_en, 1);
    check("oe rst", o_dma_cycle_oe_n, 1);
    i_resetn = 1;
    @(negedge i_clk);
    check("divided", o_divided_clock_mode, 1);
    check("pll", o_pll_enable, 0);
    check("pullup run", o_mid4_pullup_en, 0);
    i_divide_strap_in = 1;
    for (i = 0; i < 40; i = i + 1) begin
      waits = $urandom % 6;
      mode = $urandom % 3;
      i_mid_whole_range = ($urandom % 4) == 0;
      i_auxiliary_config_register = $urandom;
      bus_cycle($urandom % 7, $urandom % 2, $urandom % 2,
        i_mid_base + $urandom % 20'h0_5000);
    end
    i_bus_granted = 1;
    i_cycle_start = 1;
    i_mid_whole_range = 0;
    i_cycle_addr = i_mid_base + 20'h0_3000;
    i_refresh_control_register = 16'h8006;
    repeat (3) @(negedge i_clk);
    check("refused", o_cycle_busy, 0);
    check("sel grant", o_mid_region4_select_n, 1);
    check("oe grant", o_dma_cycle_oe_n, 1);
    measure(6);
    i_cycle_start = 0;
    i_bus_granted = 0;
    i_refresh_control_register = 16'h8002;
    measure(4);
    i_refresh_control_register = 16'h0006;
    @(negedge i_clk);
    for (i = 0; i < 20; i = i + 1) begin
      @(negedge i_clk);
      check("no strobe", o_refresh_strobe_n, 1);
    end
    i_resetn = 0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1;
    @(negedge i_clk);
    check("undivided", o_divided_clock_mode, 0);
    check("pll on", o_pll_enable, 1);
    final_report;
  end
endmodule
